// file: src/usf_dev.sv
// Device end: serial transmitter, receiver and the eight status flags.
// Assumes a synchronous register port and a remote partner at the same rate.
// Notes on behaviour
// [R1] Status register is read-only, write ignored
// [R2] Buffer-empty set at reset and data load into the shifter
// [R3] Status read then data write clears buffer-empty
// [R4] Complete set when empty and sending nothing
// [R5] Read then write, enable rise, break clears
// [R6] Receive-full set on transfer, read-read clears
// [R7] Idle set after one character of high
// [R8] Idle type picks where idle counting starts
// [R9] Status read then data read clears idle
// [R10] Idle rearms only after a new character
// [R11] Overrun set; new character and errors dropped
// [R12] Status read then data read clears overrun
// [R13] Seven start, three bit samples; disagreement noise
// [R14] Status read then data read clears noise
// [R15] Low stop bit sets framing error
// [R16] Status read then data read clears framing
// [R17] Parity mismatch sets parity error when enabled
// [R18] Status read then data read clears parity
// [R19] Length select gives nine-bit characters
// [R20] Status read latches which flags clear later
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module usf_dev
  import usf_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [1:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  usf_link_if.dev         link
);
  function automatic logic hit(input logic stb, input logic [1:0] a, input logic [1:0] t);
    return stb && (a == t);
  endfunction

  function automatic logic [10:0] build_frame(input logic [8:0] d, input logic m,
                                              input logic pe, input logic pt);
    logic [8:0] v;
    v = d;
    if (m) begin
      if (pe) v[8] = ^d[7:0] ^ pt;
      return {1'b1, v, 1'b0};
    end
    if (pe) v[7] = ^d[6:0] ^ pt;
    return {2'b11, v[7:0], 1'b0};
  endfunction

  function automatic logic in_win(input logic [3:0] p, input logic [3:0] lo);
    return (p >= lo) && (p <= SMP_HI);
  endfunction

  logic             rd_stat, rd_data, wr_data, wr_ctl2, wr_ctl1;
  logic             te_rise, sbk_wr, queue_evt;
  logic             te_q, sbk_q, m_q, ilt_q, pe_q, pt_q, t8_q;
  logic       [7:0] stat_q, arm_q, set_vec, clr_vec;
  logic       [8:0] tx_buf_q;
  logic             pre_q, tx_load, tx_load_data, tx_busy;
  logic      [10:0] tx_frame;
  logic       [1:0] div_q;
  logic             rt_tick, line;
  usf_rx_state_type rx_state_q;
  logic       [3:0] rx_rt_q, rx_idx_q, stop_idx;
  logic       [2:0] smp_q, ones_q, cur3;
  logic             rx_nz_q, rx_done_q, unread, rx_accept, rx_perr, rx_stop;
  logic       [9:0] rx_bits_q;
  logic       [7:0] rx_data_q, idle_cnt_q, idle_target;
  logic             r8_q, idle_arm_q, idle_en, idle_hit;
  logic       [7:0] rd_mux, rdata_q;

  // Register port decode; status writes decode to nothing
  assign rd_stat   = hit(rd_in, addr_in, ADDR_STATUS);
  assign rd_data   = hit(rd_in, addr_in, ADDR_DATA);
  assign wr_data   = hit(wr_in, addr_in, ADDR_DATA);
  assign wr_ctl2   = hit(wr_in, addr_in, ADDR_CTRL_TWO);
  assign wr_ctl1   = hit(wr_in, addr_in, ADDR_CTRL_ONE); // [R1]
  assign te_rise   = wr_ctl2 && wdata_in[BIT_TX_ENABLE] && !te_q;
  assign sbk_wr    = wr_ctl2 && wdata_in[BIT_SEND_BREAK];
  assign queue_evt = te_rise || sbk_wr;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      te_q  <= 1'b0;
      sbk_q <= 1'b0;
    end else if (wr_ctl2) begin
      te_q  <= wdata_in[BIT_TX_ENABLE];
      sbk_q <= wdata_in[BIT_SEND_BREAK];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      m_q   <= 1'b0;
      ilt_q <= 1'b0;
      pe_q  <= 1'b0;
      pt_q  <= 1'b0;
      t8_q  <= 1'b0;
    end else if (wr_ctl1) begin
      m_q   <= wdata_in[BIT_CHAR_LEN];
      ilt_q <= wdata_in[BIT_IDLE_TYPE];
      pe_q  <= wdata_in[BIT_PARITY_EN];
      pt_q  <= wdata_in[BIT_PARITY_ODD];
      t8_q  <= wdata_in[BIT_TX_NINTH];
    end
  end

  // Armed flags are those seen set by the last status read
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arm_q <= 8'h00;
    end else if (rd_stat) begin
      arm_q <= stat_q; // [R20]
    end else if (rd_data) begin
      arm_q <= arm_q & ~RX_FLAGS_MASK;
    end else if (wr_data) begin
      arm_q <= arm_q & ~TX_FLAGS_MASK;
    end else if (queue_evt) begin
      arm_q <= arm_q & ~TX_DONE_MASK;
    end
  end

  always_comb begin
    clr_vec = 8'h00;
    if (rd_data) clr_vec = arm_q & RX_FLAGS_MASK; // [R6] [R9] [R12] [R14] [R16] [R18]
    if (wr_data) clr_vec = arm_q & TX_FLAGS_MASK; // [R3] [R5]
    if (queue_evt) clr_vec = arm_q & TX_DONE_MASK; // [R5]
  end

  always_comb begin
    set_vec               = 8'h00;
    set_vec[BIT_TX_EMPTY] = tx_load_data; // [R2]
    set_vec[BIT_TX_DONE]  = stat_q[BIT_TX_EMPTY] && !tx_busy && !pre_q && !sbk_q
                            && !wr_data && !queue_evt; // [R4]
    set_vec[BIT_RX_FULL]  = rx_accept; // [R6]
    set_vec[BIT_IDLE]     = idle_hit; // [R7]
    set_vec[BIT_OVERRUN]  = rx_done_q && unread; // [R11]
    set_vec[BIT_NOISE]    = rx_accept && rx_nz_q; // [R13]
    set_vec[BIT_FRAMING]  = rx_accept && !rx_stop; // [R15]
    set_vec[BIT_PARITY]   = rx_accept && pe_q && rx_perr; // [R17]
  end

  // A set in the same cycle as its clear wins
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) stat_q <= STATUS_RESET; // [R2] [R4]
    else stat_q <= set_vec | (stat_q & ~clr_vec);
  end

  // Transmit side; a data write without the read-status step fills the buffer only
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) tx_buf_q <= 9'h000;
    else if (wr_data) tx_buf_q <= {t8_q, wdata_in};
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) pre_q <= 1'b0;
    else if (te_rise) pre_q <= 1'b1;
    else if (tx_load) pre_q <= 1'b0;
  end

  // Preamble first, then breaks while requested, then buffered data
  assign tx_load      = !tx_busy && te_q && (pre_q || sbk_q || !stat_q[BIT_TX_EMPTY]);
  assign tx_load_data = tx_load && !pre_q && !sbk_q;
  assign tx_frame     = pre_q ? FRAME_IDLE : sbk_q ? FRAME_BREAK
                      : build_frame(tx_buf_q, m_q, pe_q, pt_q); // [R19]

  usf_tx_shift u_tx (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .rt_tick_in (rt_tick),
    .load_in    (tx_load),
    .frame_in   (tx_frame),
    .long_in    (m_q),
    .busy_out   (tx_busy),
    .txd_out    (link.dev_to_rem)
  );

  // Sample tick, 16 per bit time
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) div_q <= 2'h0;
    else div_q <= rt_tick ? 2'h0 : div_q + 2'h1;
  end
  assign rt_tick  = (div_q == RT_DIV_LAST);
  assign line     = link.rem_to_dev;
  assign stop_idx = m_q ? STOP_IDX_LONG : STOP_IDX_SHORT; // [R19]
  assign cur3     = {smp_q[1:0], line};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_state_q <= RX_IDLE;
      rx_rt_q    <= 4'h0;
      rx_idx_q   <= 4'h0;
      smp_q      <= 3'h0;
      ones_q     <= 3'h0;
      rx_nz_q    <= 1'b0;
      rx_bits_q  <= 10'h000;
      rx_done_q  <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (rt_tick) begin
        case (rx_state_q)
          RX_IDLE: begin
            if (!line) begin
              rx_state_q <= RX_START;
              rx_rt_q    <= RT_FIRST;
              ones_q     <= 3'h0;
              rx_nz_q    <= 1'b0;
            end
          end
          RX_START: begin
            rx_rt_q <= rx_rt_q + RT_STEP;
            if (in_win(rx_rt_q, START_SMP_LO)) ones_q <= ones_q + {2'b00, line}; // [R13]
            if (in_win(rx_rt_q, SMP_LO)) smp_q <= cur3;
            if (rx_rt_q == SMP_HI) begin
              // Glitch rejection: a mostly high start bit is no start
              if (usf_maj3(cur3)) rx_state_q <= RX_IDLE;
              rx_nz_q <= (ones_q != 3'h0) || line; // [R13]
            end
            if (rx_rt_q == RT_LAST) begin
              rx_state_q <= RX_BITS;
              rx_idx_q   <= 4'h0;
            end
          end
          RX_BITS: begin
            rx_rt_q <= rx_rt_q + RT_STEP;
            if (in_win(rx_rt_q, SMP_LO)) smp_q <= cur3;
            if (rx_rt_q == SMP_HI) begin
              rx_bits_q[rx_idx_q] <= usf_maj3(cur3);
              if (cur3 != 3'h0 && cur3 != 3'h7) rx_nz_q <= 1'b1; // [R13]
              if (rx_idx_q == stop_idx) begin
                rx_done_q  <= 1'b1;
                rx_state_q <= RX_IDLE;
              end
            end
            if (rx_rt_q == RT_LAST) rx_idx_q <= rx_idx_q + 4'h1;
          end
          default: rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

  assign rx_stop   = m_q ? rx_bits_q[9] : rx_bits_q[8];
  assign rx_perr   = (m_q ? ^rx_bits_q[8:0] : ^rx_bits_q[7:0]) ^ pt_q;
  assign unread    = stat_q[BIT_RX_FULL] && !clr_vec[BIT_RX_FULL];
  assign rx_accept = rx_done_q && !unread; // [R11]

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_data_q <= 8'h00;
      r8_q      <= 1'b0;
    end else if (rx_accept) begin
      rx_data_q <= rx_bits_q[7:0];
      r8_q      <= rx_bits_q[8];
    end
  end

  // Idle detection counts high sample ticks from the chosen starting point
  assign idle_en     = ilt_q ? (rx_state_q == RX_IDLE) : (rx_state_q != RX_START); // [R8]
  assign idle_target = m_q ? IDLE_RT_LONG : IDLE_RT_SHORT; // [R7]
  assign idle_hit    = rt_tick && line && idle_en && idle_arm_q
                       && (idle_cnt_q == idle_target - 8'h01); // [R7]

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) idle_cnt_q <= 8'h00;
    else if (rt_tick && (!line || !idle_en)) idle_cnt_q <= 8'h00;
    else if (rt_tick && idle_cnt_q != idle_target) idle_cnt_q <= idle_cnt_q + 8'h01;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) idle_arm_q <= 1'b0;
    else if (rx_accept) idle_arm_q <= 1'b1; // [R10]
    else if (idle_hit) idle_arm_q <= 1'b0; // [R10]
  end

  always_comb begin
    rd_mux = 8'h00;
    case (addr_in)
      ADDR_STATUS: rd_mux = stat_q;
      ADDR_DATA:   rd_mux = rx_data_q;
      ADDR_CTRL_TWO: begin
        rd_mux[BIT_TX_ENABLE]  = te_q;
        rd_mux[BIT_SEND_BREAK] = sbk_q;
      end
      ADDR_CTRL_ONE: begin
        rd_mux[BIT_RX_NINTH]   = r8_q;
        rd_mux[BIT_TX_NINTH]   = t8_q;
        rd_mux[BIT_CHAR_LEN]   = m_q;
        rd_mux[BIT_IDLE_TYPE]  = ilt_q;
        rd_mux[BIT_PARITY_EN]  = pe_q;
        rd_mux[BIT_PARITY_ODD] = pt_q;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rdata_q <= 8'h00;
    else rdata_q <= rd_in ? rd_mux : 8'h00;
  end
  assign rdata_out = rdata_q;
endmodule

// file: src/usf_pkg.sv
// Shared constants and types of the serial status-flag block.
// Assumes one clock shared by both ends of the serial link.
package usf_pkg;

  // Bus clocks per receiver sample tick (arbitrary rate)
  localparam logic [1:0] RT_DIV_LAST = 2'h3;
  // Sample ticks within one bit time, phases 0 to 15
  localparam logic [3:0] RT_FIRST    = 4'h1;
  localparam logic [3:0] RT_STEP     = 4'h1;
  localparam logic [3:0] RT_LAST     = 4'hF;
  localparam logic [3:0] START_SMP_LO = 4'h3;
  localparam logic [3:0] SMP_LO      = 4'h7;
  localparam logic [3:0] SMP_MID     = 4'h8;
  localparam logic [3:0] SMP_HI      = 4'h9;

  // Bits per frame on the line and index of the stop bit after the start bit
  localparam logic [3:0] FRAME_BITS_SHORT = 4'hA;
  localparam logic [3:0] FRAME_BITS_LONG  = 4'hB;
  localparam logic [3:0] STOP_IDX_SHORT   = 4'h8;
  localparam logic [3:0] STOP_IDX_LONG    = 4'h9;
  // One character time of idle line, in sample ticks
  localparam logic [7:0] IDLE_RT_SHORT = 8'hA0;
  localparam logic [7:0] IDLE_RT_LONG  = 8'hB0;

  localparam logic [10:0] FRAME_IDLE  = 11'h7FF;
  localparam logic [10:0] FRAME_BREAK = 11'h000;

  // Register port map
  localparam logic [1:0] ADDR_STATUS   = 2'h0;
  localparam logic [1:0] ADDR_DATA     = 2'h1;
  localparam logic [1:0] ADDR_CTRL_TWO = 2'h2;
  localparam logic [1:0] ADDR_CTRL_ONE = 2'h3;

  // serial_status_one fields
  localparam int BIT_TX_EMPTY = 7;
  localparam int BIT_TX_DONE  = 6;
  localparam int BIT_RX_FULL  = 5;
  localparam int BIT_IDLE     = 4;
  localparam int BIT_OVERRUN  = 3;
  localparam int BIT_NOISE    = 2;
  localparam int BIT_FRAMING  = 1;
  localparam int BIT_PARITY   = 0;
  localparam logic [7:0] STATUS_RESET  = 8'hC0;
  localparam logic [7:0] RX_FLAGS_MASK = 8'h3F;
  localparam logic [7:0] TX_FLAGS_MASK = 8'hC0;
  localparam logic [7:0] TX_DONE_MASK  = 8'h40;

  // serial_control_two fields
  localparam int BIT_TX_ENABLE  = 3;
  localparam int BIT_SEND_BREAK = 0;
  // Control-one fields
  localparam int BIT_RX_NINTH   = 7;
  localparam int BIT_TX_NINTH   = 6;
  localparam int BIT_CHAR_LEN   = 4;
  localparam int BIT_IDLE_TYPE  = 2;
  localparam int BIT_PARITY_EN  = 1;
  localparam int BIT_PARITY_ODD = 0;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10
  } usf_rx_state_type;

  function automatic logic usf_maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

endpackage

// file: src/usf_link_if.sv
// Serial link between the flag-keeping device and its remote partner.
// Both ends share one clock; each line idles high.
`timescale 1ns/1ps
interface usf_link_if;
  logic dev_to_rem;
  logic rem_to_dev;
  modport dev (output dev_to_rem, input rem_to_dev);
  modport rem (input dev_to_rem, output rem_to_dev);
endinterface

// file: src/usf_tx_shift.sv
// Frame serializer: sends 10 or 11 line bits, first bit first.
// Assumes a sample tick of 16 per bit; the line idles high.
`timescale 1ns/1ps
module usf_tx_shift
  import usf_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        rt_tick_in,
  input  wire logic        load_in,
  input  wire logic [10:0] frame_in,
  input  wire logic        long_in,
  output logic             busy_out,
  output logic             txd_out
);
  logic [10:0] sh_q;
  logic [10:0] hold_q;
  logic [3:0]  rt_q;
  logic [3:0]  left_q;
  logic        busy_q;
  logic        pend_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sh_q   <= FRAME_IDLE;
      hold_q <= FRAME_IDLE;
      rt_q   <= 4'h0;
      left_q <= 4'h0;
      busy_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (load_in && !busy_q) begin
      hold_q <= frame_in;
      left_q <= long_in ? FRAME_BITS_LONG : FRAME_BITS_SHORT;
      busy_q <= 1'b1;
      pend_q <= 1'b1;
    end else if (pend_q) begin
      // Start on a sample tick so the start bit is as long as every other bit
      if (rt_tick_in) begin
        sh_q   <= hold_q;
        rt_q   <= 4'h0;
        pend_q <= 1'b0;
      end
    end else if (busy_q && rt_tick_in) begin
      rt_q <= rt_q + RT_STEP;
      if (rt_q == RT_LAST) begin
        left_q <= left_q - 4'h1;
        // Refill with ones so a break frame cannot hold the line low
        if (left_q == 4'h1) begin
          sh_q   <= FRAME_IDLE;
          busy_q <= 1'b0;
        end else begin
          sh_q <= {1'b1, sh_q[10:1]};
        end
      end
    end
  end

  assign busy_out = busy_q;
  assign txd_out  = sh_q[0];
endmodule

// file: src/usf_rem.sv
// Remote end: sends raw frames and captures frames from the device.
// Assumes the same bit rate as the device; samples each bit once mid-bit.
`timescale 1ns/1ps
module usf_rem
  import usf_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        send_in,
  input  wire logic [10:0] frame_in,
  input  wire logic        long_in,
  output logic             busy_out,
  input  wire logic        rx_long_in,
  output logic             rx_valid_out,
  output logic       [9:0] rx_frame_out,
  usf_link_if.rem          link
);
  logic [1:0] div_q;
  logic       rt_tick, line, act_q, valid_q;
  logic [3:0] rt_q, idx_q, stop_idx;
  logic [9:0] bits_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) div_q <= 2'h0;
    else div_q <= rt_tick ? 2'h0 : div_q + 2'h1;
  end
  assign rt_tick  = (div_q == RT_DIV_LAST);
  assign line     = link.dev_to_rem;
  assign stop_idx = rx_long_in ? STOP_IDX_LONG : STOP_IDX_SHORT;

  usf_tx_shift u_tx (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .rt_tick_in (rt_tick),
    .load_in    (send_in),
    .frame_in   (frame_in),
    .long_in    (long_in),
    .busy_out   (busy_out),
    .txd_out    (link.rem_to_dev)
  );

  // Capture after the start bit, one sample per bit, no noise check
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      act_q   <= 1'b0;
      rt_q    <= 4'h0;
      idx_q   <= 4'h0;
      bits_q  <= 10'h000;
      valid_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      if (rt_tick) begin
        if (!act_q) begin
          if (!line) begin
            act_q <= 1'b1;
            rt_q  <= RT_FIRST;
            idx_q <= 4'hF;
          end
        end else begin
          rt_q <= rt_q + RT_STEP;
          if (rt_q == RT_LAST) idx_q <= idx_q + 4'h1;
          if (rt_q == SMP_MID && idx_q != 4'hF) begin
            bits_q[idx_q] <= line;
            if (idx_q == stop_idx) begin
              valid_q <= 1'b1;
              act_q   <= 1'b0;
            end
          end
        end
      end
    end
  end

  assign rx_valid_out = valid_q;
  assign rx_frame_out = bits_q;
endmodule

// file: tb/usf_link_checker.sv
// Checker for the serial link lines and the register read port.
// Assumes one clock; the bench places it beside the link interface.
`timescale 1ns/1ps
module usf_link_checker
  import usf_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       dev_to_rem,
  input  wire logic       rem_to_dev,
  input  wire logic       rd_in,
  input  wire logic [1:0] addr_in,
  input  wire logic [7:0] rdata_out
);
  logic [11:0] dev_low_q;
  logic [11:0] rem_low_q;
  logic [7:0]  dev_high_q;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Bits last 64 clocks, so every low run on a line is a whole number of bits
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dev_low_q <= 12'h000;
      rem_low_q <= 12'h000;
    end else begin
      dev_low_q <= dev_to_rem ? 12'h000 : dev_low_q + 12'h001;
      rem_low_q <= rem_to_dev ? 12'h000 : rem_low_q + 12'h001;
    end
  end

  // Saturates so a line idle since reset counts as long idle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dev_high_q <= 8'hFF;
    end else if (!dev_to_rem) begin
      dev_high_q <= 8'h00;
    end else if (dev_high_q != 8'hFF) begin
      dev_high_q <= dev_high_q + 8'h01;
    end
  end

  property p_rd_quiet;
    !$past(rd_in) |-> rdata_out == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
  property p_noise_full;
    rd_in && addr_in == ADDR_STATUS ##1 rdata_out[BIT_NOISE] |-> rdata_out[BIT_RX_FULL];
  endproperty
  a_noise_full: assert property (p_noise_full) else $error("noise without rx full");
  property p_frame_full;
    rd_in && addr_in == ADDR_STATUS |=> !rdata_out[BIT_FRAMING] || rdata_out[BIT_RX_FULL];
  endproperty
  a_frame_full: assert property (p_frame_full) else $error("framing without rx full");
  property p_parity_full;
    rd_in && addr_in == ADDR_STATUS |=> !rdata_out[BIT_PARITY] || rdata_out[BIT_RX_FULL];
  endproperty
  a_parity_full: assert property (p_parity_full) else $error("parity without rx full");
  property p_done_empty;
    rd_in && addr_in == ADDR_STATUS |=> !rdata_out[BIT_TX_DONE] || rdata_out[BIT_TX_EMPTY];
  endproperty
  a_done_empty: assert property (p_done_empty) else $error("complete with buffer full");
  property p_dev_bits;
    $rose(dev_to_rem) |-> dev_low_q[5:0] == 6'h00;
  endproperty
  a_dev_bits: assert property (p_dev_bits) else $error("device low run not whole bits");
  property p_rem_bits;
    $rose(rem_to_dev) |-> rem_low_q[5:0] == 6'h00;
  endproperty
  a_rem_bits: assert property (p_rem_bits) else $error("remote low run not whole bits");
  property p_dev_start;
    $fell(dev_to_rem) |-> ##63 !dev_to_rem;
  endproperty
  a_dev_start: assert property (p_dev_start) else $error("start bit too short");
  property p_dev_gap;
    $fell(dev_to_rem) |-> dev_high_q >= 8'h40;
  endproperty
  a_dev_gap: assert property (p_dev_gap) else $error("stop bit too short");
endmodule

// file: tb/tb.sv
// Bench for the serial status-flag block: device and remote joined by the link.
// Assumes the register map and flag positions of the shared package.
`timescale 1ns/1ps
module tb
  import usf_pkg::*;
;
  logic        clk_in;
  logic        rst_b_in;
  logic [1:0]  addr_q;
  logic [7:0]  wdata_q;
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  rdata;
  logic        send_q;
  logic [10:0] frame_q;
  logic        long_q;
  logic        rxlong_q;
  logic        busy;
  logic        rx_valid;
  logic [9:0]  rx_frame;
  int          mismatches;
  int          tests_run;
  int          seed;
  int          n;
  logic [8:0]  d9;
  logic [8:0]  d2;
  logic [7:0]  c1;

  usf_link_if usf_link_if_inst ();
  usf_dev usf_dev_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_q),
    .wdata_in(wdata_q), .wr_in(wr_q), .rd_in(rd_q), .rdata_out(rdata),
    .link(usf_link_if_inst));
  usf_rem usf_rem_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .send_in(send_q),
    .frame_in(frame_q), .long_in(long_q), .busy_out(busy), .rx_long_in(rxlong_q),
    .rx_valid_out(rx_valid), .rx_frame_out(rx_frame), .link(usf_link_if_inst));
  usf_link_checker usf_link_checker_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .dev_to_rem(usf_link_if_inst.dev_to_rem), .rem_to_dev(usf_link_if_inst.rem_to_dev),
    .rd_in(rd_q), .addr_in(addr_q), .rdata_out(rdata));

  always #2 clk_in = ~clk_in;

  function automatic logic [10:0] make_frame(input logic lng, input logic [8:0] d,
                                             input logic stp);
    return lng ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
  endfunction
  function automatic logic par_err(input logic lng, input logic [8:0] d,
                                   input logic en, input logic odd);
    return en & ((lng ? ^d : ^d[7:0]) != odd);
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic guard();
    if (n >= 3000) begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_q  <= a;
    wdata_q <= d;
    wr_q    <= 1'b1;
    @(posedge clk_in);
    wr_q <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look just past that edge
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_q <= a;
    rd_q   <= 1'b1;
    @(posedge clk_in);
    rd_q <= 1'b0;
    #1;
    check({2'b00, rdata}, {2'b00, exp});
  endtask
  task automatic send(input logic [10:0] f, input logic lng);
    @(posedge clk_in);
    send_q  <= 1'b1;
    frame_q <= f;
    long_q  <= lng;
    @(posedge clk_in);
    send_q <= 1'b0;
    #1;
    for (n = 0; n < 3000 && busy !== 1'b0; n++) begin
      @(posedge clk_in);
      #1;
    end
    guard();
  endtask
  task automatic tx_case(input logic lng, input logic [8:0] d);
    @(posedge clk_in);
    rxlong_q <= lng;
    wr(ADDR_CTRL_ONE, {1'b0, d[8], 1'b0, lng, 4'h0});
    rd(ADDR_STATUS, STATUS_RESET);
    wr(ADDR_DATA, d[7:0]);
    repeat (8) @(posedge clk_in);
    rd(ADDR_STATUS, 8'h80);
    for (n = 0; n < 3000 && rx_valid !== 1'b1; n++) begin
      @(posedge clk_in);
      #1;
    end
    guard();
    check(lng ? rx_frame : {1'b0, rx_frame[8:0]}, lng ? {1'b1, d} : {2'b01, d[7:0]});
    repeat (64) @(posedge clk_in);
    rd(ADDR_STATUS, STATUS_RESET);
  endtask

  initial begin
    clk_in = 1'b0;
    rst_b_in = 1'b0;
    addr_q = 2'h0;
    wdata_q = 8'h00;
    wr_q = 1'b0;
    rd_q = 1'b0;
    send_q = 1'b0;
    frame_q = FRAME_IDLE;
    long_q = 1'b0;
    rxlong_q = 1'b0;
    mismatches = 0;
    tests_run = 0;
    seed = 32'h1818;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(ADDR_STATUS, STATUS_RESET);
    wr(ADDR_STATUS, 8'h3F);
    rd(ADDR_STATUS, STATUS_RESET);
    // First enable rise queues a preamble; let it drain before the data cases
    wr(ADDR_CTRL_TWO, 8'h08);
    rd(ADDR_STATUS, 8'h80);
    repeat (800) @(posedge clk_in);
    tx_case(1'b0, 9'h000);
    tx_case(1'b1, 9'h1FF);
    tx_case(1'b0, 9'($random(seed)));
    tx_case(1'b1, 9'($random(seed)));
    // Enable toggle queues a preamble; break then holds the line low
    wr(ADDR_CTRL_TWO, 8'h00);
    rd(ADDR_STATUS, STATUS_RESET);
    wr(ADDR_CTRL_TWO, 8'h08);
    rd(ADDR_STATUS, 8'h80);
    repeat (800) @(posedge clk_in);
    rd(ADDR_STATUS, STATUS_RESET);
    wr(ADDR_CTRL_TWO, 8'h09);
    rd(ADDR_STATUS, 8'h80);
    wr(ADDR_CTRL_TWO, 8'h08);
    repeat (1600) @(posedge clk_in);
    rd(ADDR_STATUS, STATUS_RESET);
    // Receive table over length, parity, odd and idle type, with bad stop bits
    for (int i = 0; i < 12; i++) begin
      d9 = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
      c1 = {3'b000, 1'(i), 1'b0, 1'(i >> 3), 1'(i >> 1), 1'(i >> 2)};
      wr(ADDR_CTRL_ONE, c1);
      send(make_frame(c1[4], d9, i % 3 != 0), c1[4]);
      repeat (800) @(posedge clk_in);
      rd(ADDR_STATUS, {6'b111100, i % 3 == 0, par_err(c1[4], d9, c1[1], c1[0])});
      if (c1[4])
        rd(ADDR_CTRL_ONE, {d9[8], c1[6:0]});
      rd(ADDR_DATA, d9[7:0]);
      repeat (800) @(posedge clk_in);
      rd(ADDR_STATUS, STATUS_RESET);
    end
    // Second character lands while the first is unread
    wr(ADDR_CTRL_ONE, 8'h00);
    d9 = 9'($random(seed));
    d2 = 9'($random(seed));
    send(make_frame(1'b0, d9, 1'b1), 1'b0);
    send(make_frame(1'b0, d2, 1'b0), 1'b0);
    repeat (800) @(posedge clk_in);
    rd(ADDR_STATUS, 8'hF8);
    rd(ADDR_DATA, d9[7:0]);
    rd(ADDR_STATUS, STATUS_RESET);
    conclude();
  end
endmodule
